// ---- rcc_bcd_check.sv ----
/*
  BCD validity check of a four-digit word.
  Purely combinational; the caller decides when the answer matters.
*/
`timescale 1ns/100ps
module rcc_bcd_check (
  input wire logic [rcc_pkg::PV_W-1:0] word_i,
  output logic valid_o
);

  logic [rcc_pkg::DIGITS-1:0] digit_ok;

  genvar g;
  generate
    for (g = 0; g < rcc_pkg::DIGITS; g++) begin : g_digit
      assign digit_ok[g] = (word_i[4*g +: 4] <= 4'h9);
    end
  endgenerate

  assign valid_o = &digit_ok;

endmodule

// ---- rcc_bcd_step.sv ----
/*
  Four-digit BCD increment and decrement, both results at once.
  Assumes a valid BCD operand; a non-BCD digit gives an unspecified result.
*/
`timescale 1ns/100ps
module rcc_bcd_step (
  input wire logic [rcc_pkg::PV_W-1:0] value_i,
  output logic [rcc_pkg::PV_W-1:0] inc_o,
  output logic [rcc_pkg::PV_W-1:0] dec_o
);

  logic [rcc_pkg::DIGITS:0] carry;
  logic [rcc_pkg::DIGITS:0] borrow;

  assign carry[0] = 1'b1;
  assign borrow[0] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < rcc_pkg::DIGITS; g++) begin : g_digit
      logic [3:0] d;
      assign d = value_i[4*g +: 4];
      // Digit carry at nine, borrow at zero
      assign carry[g+1] = carry[g] & (d == 4'h9);
      assign borrow[g+1] = borrow[g] & (d == 4'h0);
      assign inc_o[4*g +: 4] = !carry[g] ? d : ((d == 4'h9) ? 4'h0 : 4'(d + 4'h1));
      assign dec_o[4*g +: 4] = !borrow[g] ? d : ((d == 4'h0) ? 4'h9 : 4'(d - 4'h1));
    end
  endgenerate

endmodule

// ---- rcc_pkg.sv ----
/*
  Package for the reversible wrap counter: register map, field positions,
  reset values and the carrier structs shared by the top and its helpers.
  Assumes a 32-bit APB master and a scan controller that pulses one
  execution strobe per program scan.
*/
// Functional notes
// - Count-up input rising since last execution adds one to the present value.
// - Count-down input rising since last execution subtracts one from present value.
// - Both inputs rising since last execution leaves present value unchanged.
// - No rising input, steady or falling, leaves present value unchanged.
// - Decrement from zero loads set value; completion holds until next decrement.
// - Increment past set value loads zero; completion holds until next increment.
// - Rising reset input clears present value to zero.
// - While reset input is on, counts are ignored; counting resumes after release.
// - Present value is kept in interlocked sections and across power loss; here power-on reset (rst_n_i) clears it to zero.
// - Non-BCD set value raises error flag; counting continues, result not guaranteed.
// - Non-BCD or out-of-area indirect address word also raises error flag.
package rcc_pkg;

  localparam int unsigned DIGITS = 4;
  localparam int unsigned PV_W = 16;

  localparam logic [7:0] OFS_SET_VALUE = 8'h00;
  localparam logic [7:0] OFS_IND_ADDR = 8'h04;
  localparam logic [7:0] OFS_PRESENT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

  localparam int unsigned IND_EN_BIT = 16;
  localparam int unsigned PRS_COMP_BIT = 16;
  localparam int unsigned PRS_ERR_BIT = 17;

  localparam int unsigned IRQ_N = 3;
  localparam int unsigned IRQ_WRAP_UP = 0;
  localparam int unsigned IRQ_WRAP_DN = 1;
  localparam int unsigned IRQ_ERROR = 2;

  localparam logic [PV_W-1:0] SV_RESET = 16'h0000;
  localparam logic [PV_W:0] IND_RESET = 17'h00000;
  localparam logic [PV_W-1:0] PV_ZERO = 16'h0000;
  localparam logic [IRQ_N-1:0] IRQ_RESET = 3'h0;
  // Highest legal indirect word address, in BCD
  localparam logic [PV_W-1:0] IND_AREA_MAX = 16'h6143;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } rcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcc_apb_rsp_t;

  typedef struct packed {
    logic [PV_W-1:0] pv;
    logic up_prev;
    logic dn_prev;
    logic comp;
    logic comp_up;
    logic err;
    logic [PV_W-1:0] sv;
    logic [PV_W:0] ind;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_en;
    logic [31:0] prdata;
    logic pslverr;
  } rcc_state_t;

endpackage

// ---- rcc_scan_model.sv ----
/*
  Scan controller model for the wrap counter.
  It gives one execution strobe per scan, together with the count, reset and
  interlock levels for that scan. The bench calls run_scan from one process only.
*/
`timescale 1ns/100ps
module rcc_scan_model #(
  parameter int unsigned COUNTER_NUMBER = 0
) (
  input wire logic core_clk_i,
  output logic scan_exec_o,
  output logic interlock_o,
  output logic count_up_o,
  output logic count_down_o,
  output logic count_reset_o
);
  initial begin
    scan_exec_o = 1'b0;
    interlock_o = 1'b0;
    count_up_o = 1'b0;
    count_down_o = 1'b0;
    count_reset_o = 1'b0;
  end

  // Levels stay up to the next scan, so no short pulse can be missed
  task automatic run_scan(input logic up, input logic dn, input logic rs, input logic lk);
    @(posedge core_clk_i);
    count_up_o <= up;
    count_down_o <= dn;
    count_reset_o <= rs;
    interlock_o <= lk;
    scan_exec_o <= 1'b1;
    @(posedge core_clk_i);
    scan_exec_o <= 1'b0;
  endtask
endmodule

// ---- rcc_updown_wrap_counter.sv ----
/*
  Reversible wrap counter evaluated once per program scan, with APB
  register access and a level interrupt.
  Assumes scan_exec_i is a one-cycle strobe per execution and the count
  and reset inputs are stable, synchronous levels sampled on that strobe.
*/
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module rcc_updown_wrap_counter (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scan_exec_i,
  input wire logic interlock_i,
  input wire logic count_up_input_i,
  input wire logic count_down_input_i,
  input wire logic count_reset_i,
  input wire rcc_pkg::rcc_apb_req_t apb_req_i,
  output rcc_pkg::rcc_apb_rsp_t apb_rsp_o,
  output logic [rcc_pkg::PV_W-1:0] present_value_o,
  output logic completion_o,
  output logic error_flag_o,
  output logic irq_o
);

  rcc_pkg::rcc_state_t s_q;
  rcc_pkg::rcc_state_t s_d;

  logic [rcc_pkg::PV_W-1:0] pv_inc;
  logic [rcc_pkg::PV_W-1:0] pv_dec;
  logic sv_ok;
  logic ind_ok;
  logic exec;
  logic up_rise;
  logic dn_rise;
  logic wrap_up;
  logic wrap_dn;
  logic err_now;
  logic ind_bad;
  logic setup;
  logic wr_acc;
  logic [7:0] addr;
  logic [rcc_pkg::IRQ_N-1:0] irq_set;
  logic [rcc_pkg::IRQ_N-1:0] irq_clr;

  rcc_bcd_step u_step (
    .value_i(s_q.pv),
    .inc_o(pv_inc),
    .dec_o(pv_dec)
  );

  rcc_bcd_check u_sv_check (
    .word_i(s_q.sv),
    .valid_o(sv_ok)
  );

  rcc_bcd_check u_ind_check (
    .word_i(s_q.ind[rcc_pkg::PV_W-1:0]),
    .valid_o(ind_ok)
  );

  // An interlocked scan is not an execution: all count state just holds
  assign exec = scan_exec_i & !interlock_i;
  assign up_rise = count_up_input_i & !s_q.up_prev;
  assign dn_rise = count_down_input_i & !s_q.dn_prev;
  // Greater-or-equal covers a set value lowered below the present value
  assign wrap_up = exec & !count_reset_i & up_rise & !dn_rise & (s_q.pv >= s_q.sv);
  assign wrap_dn = exec & !count_reset_i & dn_rise & !up_rise & (s_q.pv == rcc_pkg::PV_ZERO);
  assign ind_bad = s_q.ind[rcc_pkg::IND_EN_BIT] &
                   (!ind_ok | (s_q.ind[rcc_pkg::PV_W-1:0] > rcc_pkg::IND_AREA_MAX));
  assign err_now = !sv_ok | ind_bad;

  assign setup = apb_req_i.psel & !apb_req_i.penable;
  assign wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  assign addr = apb_req_i.paddr[7:0];

  always_comb begin
    irq_set = '0;
    irq_set[rcc_pkg::IRQ_WRAP_UP] = wrap_up;
    irq_set[rcc_pkg::IRQ_WRAP_DN] = wrap_dn;
    irq_set[rcc_pkg::IRQ_ERROR] = exec & err_now;
    irq_clr = '0;
    if (wr_acc && addr == rcc_pkg::OFS_IRQ_CLEAR) begin
      irq_clr = apb_req_i.pwdata[rcc_pkg::IRQ_N-1:0];
    end
  end

  always_comb begin
    s_d = s_q;
    if (exec) begin
      s_d.up_prev = count_up_input_i;
      s_d.dn_prev = count_down_input_i;
      s_d.err = err_now;
      if (count_reset_i) begin
        // Held at zero for as long as the reset input stays on
        s_d.pv = rcc_pkg::PV_ZERO;
        s_d.comp = 1'b0;
        s_d.comp_up = 1'b0;
      end else if (up_rise && dn_rise) begin
        s_d.pv = s_q.pv;
      end else if (up_rise) begin
        if (wrap_up) begin
          s_d.pv = rcc_pkg::PV_ZERO;
          s_d.comp = 1'b1;
          s_d.comp_up = 1'b1;
        end else begin
          s_d.pv = pv_inc;
          if (s_q.comp_up) begin
            s_d.comp = 1'b0;
          end
        end
      end else if (dn_rise) begin
        if (wrap_dn) begin
          // A non-BCD set value is loaded as is
          s_d.pv = s_q.sv;
          s_d.comp = 1'b1;
          s_d.comp_up = 1'b0;
        end else begin
          s_d.pv = pv_dec;
          if (!s_q.comp_up) begin
            s_d.comp = 1'b0;
          end
        end
      end else begin
        s_d.pv = s_q.pv;
      end
    end

    // Set wins over a clear in the same cycle
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

    if (wr_acc) begin
      unique case (addr)
        rcc_pkg::OFS_SET_VALUE: begin
          s_d.sv = apb_req_i.pwdata[rcc_pkg::PV_W-1:0];
        end
        rcc_pkg::OFS_IND_ADDR: begin
          s_d.ind = apb_req_i.pwdata[rcc_pkg::PV_W:0];
        end
        rcc_pkg::OFS_IRQ_ENABLE: begin
          s_d.irq_en = apb_req_i.pwdata[rcc_pkg::IRQ_N-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read data and error are prepared in setup so the access needs no wait
    if (setup) begin
      s_d.prdata = '0;
      s_d.pslverr = 1'b0;
      unique case (addr)
        rcc_pkg::OFS_SET_VALUE: begin
          s_d.prdata[rcc_pkg::PV_W-1:0] = s_q.sv;
        end
        rcc_pkg::OFS_IND_ADDR: begin
          s_d.prdata[rcc_pkg::PV_W:0] = s_q.ind;
        end
        rcc_pkg::OFS_PRESENT: begin
          s_d.prdata[rcc_pkg::PV_W-1:0] = s_q.pv;
          s_d.prdata[rcc_pkg::PRS_COMP_BIT] = s_q.comp;
          s_d.prdata[rcc_pkg::PRS_ERR_BIT] = s_q.err;
          s_d.pslverr = apb_req_i.pwrite;
        end
        rcc_pkg::OFS_IRQ_STATUS: begin
          s_d.prdata[rcc_pkg::IRQ_N-1:0] = s_q.irq_stat;
          s_d.pslverr = apb_req_i.pwrite;
        end
        rcc_pkg::OFS_IRQ_CLEAR: begin
          s_d.pslverr = !apb_req_i.pwrite;
        end
        rcc_pkg::OFS_IRQ_ENABLE: begin
          s_d.prdata[rcc_pkg::IRQ_N-1:0] = s_q.irq_en;
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  // Power-on reset clears the count; the reset input and an up wrap also zero it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.pv <= rcc_pkg::PV_ZERO;
      s_q.up_prev <= 1'b0;
      s_q.dn_prev <= 1'b0;
      s_q.comp <= 1'b0;
      s_q.comp_up <= 1'b0;
      s_q.err <= 1'b0;
      s_q.sv <= rcc_pkg::SV_RESET;
      s_q.ind <= rcc_pkg::IND_RESET;
      s_q.irq_stat <= rcc_pkg::IRQ_RESET;
      s_q.irq_en <= rcc_pkg::IRQ_RESET;
      s_q.prdata <= 32'h00000000;
      s_q.pslverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp_o.prdata = s_q.prdata;
  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = s_q.pslverr;
  assign present_value_o = s_q.pv;
  assign completion_o = s_q.comp;
  assign error_flag_o = s_q.err;
  assign irq_o = |(s_q.irq_stat & s_q.irq_en);

  chk_up_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && up_rise && !dn_rise && !count_reset_i && s_q.pv < s_q.sv |=> s_q.pv == $past(pv_inc))
    else $error("Increment did not add one");

  chk_down_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && dn_rise && !up_rise && !count_reset_i && s_q.pv != 16'h0000 |=> s_q.pv == $past(pv_dec))
    else $error("Decrement did not subtract one");

  chk_both_rise: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && up_rise && dn_rise && !count_reset_i |=> $stable(s_q.pv) && $stable(s_q.comp))
    else $error("Simultaneous edges changed the count");

  chk_no_edge: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(exec && (up_rise || dn_rise || count_reset_i)) |=> $stable(s_q.pv))
    else $error("Count changed without an edge");

  chk_down_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && dn_rise && !up_rise && !count_reset_i && s_q.pv == 16'h0000
    |=> s_q.pv == $past(s_q.sv) && completion_o && !s_q.comp_up)
    else $error("Down wrap did not load set value");

  chk_up_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && up_rise && !dn_rise && !count_reset_i && s_q.pv >= s_q.sv
    |=> s_q.pv == 16'h0000 && completion_o && s_q.comp_up && s_q.irq_stat[0])
    else $error("Up wrap did not return to zero");

  chk_reset_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && count_reset_i |=> s_q.pv == 16'h0000 && !completion_o)
    else $error("Reset input did not clear count");

  chk_reset_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    count_reset_i && s_q.pv == 16'h0000 |=> s_q.pv == 16'h0000)
    else $error("Counted while reset input on");

  chk_interlock_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    interlock_i [*2] |-> $stable(s_q.pv) && $stable(s_q.up_prev) && $stable(s_q.dn_prev))
    else $error("Count moved while interlocked");

  chk_sv_error: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && !sv_ok |=> error_flag_o && s_q.irq_stat[2])
    else $error("Bad set value not flagged");

  chk_ind_error: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && s_q.ind[16] && s_q.ind[15:0] > 16'h6143 |=> error_flag_o)
    else $error("Bad indirect address not flagged");

  chk_error_clean: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && sv_ok && !s_q.ind[16] |=> !error_flag_o)
    else $error("Error flag raised without cause");

  // Edge memory and completion ownership
  chk_edge_memory: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec |=> s_q.up_prev == $past(count_up_input_i) && s_q.dn_prev == $past(count_down_input_i))
    else $error("Edge memory not updated at execution");

  chk_dn_comp_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && dn_rise && !up_rise && !count_reset_i && s_q.pv != 16'h0000 && !s_q.comp_up |=> !completion_o)
    else $error("Decrement left down wrap flag set");

  chk_up_comp_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && up_rise && !dn_rise && !count_reset_i && s_q.pv < s_q.sv && s_q.comp_up |=> !completion_o)
    else $error("Increment left up wrap flag set");

  chk_up_comp_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && up_rise && !dn_rise && !count_reset_i && s_q.pv < s_q.sv && !s_q.comp_up |=> $stable(completion_o))
    else $error("Increment disturbed down wrap flag");

  chk_dn_comp_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && dn_rise && !up_rise && !count_reset_i && s_q.pv != 16'h0000 && s_q.comp_up |=> $stable(completion_o))
    else $error("Decrement disturbed up wrap flag");

  chk_dn_wrap_stat: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wrap_dn |=> s_q.irq_stat[rcc_pkg::IRQ_WRAP_DN])
    else $error("Down wrap not recorded in status");

  chk_interlock_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    interlock_i |=> $stable(s_q.comp) && $stable(s_q.err))
    else $error("Flags moved while interlocked");

  // Register path checks
  chk_sv_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_acc && addr == rcc_pkg::OFS_SET_VALUE |=> s_q.sv == $past(apb_req_i.pwdata[rcc_pkg::PV_W-1:0]))
    else $error("Set value write not taken");

  chk_ind_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_acc && addr == rcc_pkg::OFS_IND_ADDR |=> s_q.ind == $past(apb_req_i.pwdata[rcc_pkg::PV_W:0]))
    else $error("Indirect word write not taken");

  chk_pv_readout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    setup && addr == rcc_pkg::OFS_PRESENT |=> apb_rsp_o.prdata[rcc_pkg::PV_W-1:0] == $past(s_q.pv))
    else $error("Present value read back wrong");

  chk_flag_readout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    setup && addr == rcc_pkg::OFS_PRESENT |=> apb_rsp_o.prdata[rcc_pkg::PRS_ERR_BIT] == $past(s_q.err)
    && apb_rsp_o.prdata[rcc_pkg::PRS_COMP_BIT] == $past(s_q.comp))
    else $error("Flags read back wrong");

  chk_ind_nonbcd: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    exec && s_q.ind[rcc_pkg::IND_EN_BIT] && !ind_ok |=> error_flag_o)
    else $error("Non-BCD indirect word not flagged");

  chk_stat_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_acc && addr == rcc_pkg::OFS_IRQ_CLEAR && !exec
    |=> (s_q.irq_stat & $past(apb_req_i.pwdata[rcc_pkg::IRQ_N-1:0])) == 3'h0)
    else $error("Status bits not cleared");

endmodule

// ---- rcc_updown_wrap_counter_tb.sv ----
/*
  Self-checking bench for the reversible wrap counter.
  Assumes the scan model drives the strobe and levels; the bench acts as APB master.
*/
`timescale 1ns/100ps
module rcc_updown_wrap_counter_tb;
  localparam logic [7:0] SVA = rcc_pkg::OFS_SET_VALUE;
  localparam logic [7:0] STA = rcc_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] ENA = rcc_pkg::OFS_IRQ_ENABLE;
  localparam logic [7:0] CLA = rcc_pkg::OFS_IRQ_CLEAR;
  localparam logic [7:0] IDA = rcc_pkg::OFS_IND_ADDR;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rcc_pkg::rcc_apb_req_t req = '0;
  rcc_pkg::rcc_apb_rsp_t rsp;
  logic exec, lock, up, dn, rs, comp, err, irq;
  logic [15:0] pv;
  logic [31:0] rd;
  int mismatches = 0;
  int check_count = 0;

  always #4 core_clk_i = ~core_clk_i;

  rcc_scan_model scan (.core_clk_i(core_clk_i), .scan_exec_o(exec), .interlock_o(lock),
    .count_up_o(up), .count_down_o(dn), .count_reset_o(rs));

  rcc_updown_wrap_counter dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scan_exec_i(exec),
    .interlock_i(lock), .count_up_input_i(up), .count_down_input_i(dn), .count_reset_i(rs),
    .apb_req_i(req), .apb_rsp_o(rsp), .present_value_o(pv), .completion_o(comp),
    .error_flag_o(err), .irq_o(irq));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Master keeps the request steady until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic ee);
    int n;
    @(posedge core_clk_i);
    req <= '{paddr: {24'h000000, a}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk_i);
      if (rsp.pready === 1'b1) break;
    end
    if (n == 16) begin
      mismatches++;
      give_verdict();
    end
    rd = rsp.prdata;
    check(32'(rsp.pslverr), 32'(ee));
    req <= '0;
  endtask

  task automatic step(input logic u, d, r, l, input logic [15:0] epv, input logic ec, ee);
    scan.run_scan(u, d, r, l);
    @(negedge core_clk_i);
    check(32'(pv), 32'(epv));
    check(32'(comp), 32'(ec));
    check(32'(err), 32'(ee));
  endtask

  task automatic irq_is(input logic e);
    @(negedge core_clk_i);
    check(32'(irq), 32'(e));
  endtask

  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, rcc_pkg::OFS_PRESENT, 32'h0, 1'b0);
    check(rd, 32'h0);
    apb(1'b0, ENA, 32'h0, 1'b0);
    check(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0, 1'b1);
    apb(1'b1, rcc_pkg::OFS_PRESENT, 32'hffff, 1'b1);
    apb(1'b0, CLA, 32'h0, 1'b1);
    apb(1'b1, SVA, 32'h2, 1'b0);
    apb(1'b0, SVA, 32'h0, 1'b0);
    check(rd, 32'h00000002);
    step(1, 0, 0, 0, 16'h0001, 0, 0);
    step(1, 0, 0, 0, 16'h0001, 0, 0);
    step(0, 0, 0, 0, 16'h0001, 0, 0);
    step(1, 0, 0, 0, 16'h0002, 0, 0);
    step(0, 0, 0, 0, 16'h0002, 0, 0);
    step(1, 0, 0, 0, 16'h0000, 1, 0);
    step(0, 0, 0, 0, 16'h0000, 1, 0);
    apb(1'b0, STA, 32'h0, 1'b0);
    check(rd, 32'h1);
    step(1, 0, 0, 0, 16'h0001, 0, 0);
    step(1, 1, 0, 0, 16'h0000, 0, 0);
    step(0, 0, 0, 0, 16'h0000, 0, 0);
    step(0, 1, 0, 0, 16'h0002, 1, 0);
    step(0, 0, 0, 0, 16'h0002, 1, 0);
    step(0, 1, 0, 0, 16'h0001, 0, 0);
    step(0, 0, 0, 0, 16'h0001, 0, 0);
    step(1, 1, 0, 0, 16'h0001, 0, 0);
    step(0, 0, 0, 0, 16'h0001, 0, 0);
    step(1, 0, 0, 1, 16'h0001, 0, 0);
    step(1, 0, 0, 0, 16'h0002, 0, 0);
    step(1, 0, 1, 0, 16'h0000, 0, 0);
    step(0, 1, 1, 0, 16'h0000, 0, 0);
    step(0, 0, 0, 0, 16'h0000, 0, 0);
    step(1, 0, 0, 0, 16'h0001, 0, 0);
    apb(1'b1, SVA, 32'h100, 1'b0);
    step(0, 1, 0, 0, 16'h0000, 0, 0);
    step(0, 0, 0, 0, 16'h0000, 0, 0);
    step(0, 1, 0, 0, 16'h0100, 1, 0);
    apb(1'b0, rcc_pkg::OFS_PRESENT, 32'h0, 1'b0);
    check(rd, 32'h00010100);
    step(0, 0, 0, 0, 16'h0100, 1, 0);
    step(0, 1, 0, 0, 16'h0099, 0, 0);
    step(1, 0, 0, 0, 16'h0100, 0, 0);
    apb(1'b1, ENA, 32'h2, 1'b0);
    irq_is(1'b1);
    apb(1'b1, CLA, 32'h3, 1'b0);
    irq_is(1'b0);
    apb(1'b1, SVA, 32'ha0, 1'b0);
    step(0, 0, 0, 0, 16'h0100, 0, 1);
    apb(1'b0, rcc_pkg::OFS_PRESENT, 32'h0, 1'b0);
    check(rd, 32'h00020100);
    apb(1'b1, ENA, 32'h4, 1'b0);
    irq_is(1'b1);
    apb(1'b1, SVA, 32'h100, 1'b0);
    apb(1'b1, IDA, 32'h16144, 1'b0);
    apb(1'b0, IDA, 32'h0, 1'b0);
    check(rd, 32'h00016144);
    step(0, 0, 0, 0, 16'h0100, 0, 1);
    apb(1'b1, IDA, 32'h100f0, 1'b0);
    step(0, 0, 0, 0, 16'h0100, 0, 1);
    apb(1'b1, IDA, 32'h16143, 1'b0);
    step(0, 0, 0, 0, 16'h0100, 0, 0);
    apb(1'b1, CLA, 32'h4, 1'b0);
    irq_is(1'b0);
    apb(1'b0, STA, 32'h0, 1'b0);
    check(rd, 32'h0);
    give_verdict();
  end
endmodule
